// file: verilog/csr_top.sv
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "csr_cfg.svh"

module csr_top
	import csr_pkg::*;
(
	input wire logic CLK, // core clock, 250 MHz
	input wire logic RST, // async reset, active high
	input wire logic [`CSR_ADDR_W-1:0] AVS_ADDRESS, // byte address
	input wire logic AVS_READ, // read request
	input wire logic AVS_WRITE, // write request
	input wire logic [`CSR_DATA_W-1:0] AVS_WRITEDATA, // write data
	input wire logic [`CSR_BE_W-1:0] AVS_BYTEENABLE, // byte lanes
	output logic [`CSR_DATA_W-1:0] AVS_READDATA, // read data
	output logic AVS_WAITREQUEST, // low for one cycle = done
	input wire csr_evt_t EVT, // one-cycle event pulses
	input wire logic [`CSR_SP_W-1:0] STACK_PTR, // core stack pointer
	input wire logic BOD_EN, // brown-out detect configured on
	input wire logic [`CSR_IRQ_N-1:0] IRQ_SRC, // pending sources
	output logic CORE_IRQ, // gated interrupt to the core
	output logic [7:0] STATUS_OUT, // status byte to the core
	output logic IRQ // event interrupt, level
);

	csr_bus_st_t bus_q;
	csr_bus_st_t bus_d;
	logic wait_q;
	logic wait_d;
	logic [`CSR_DATA_W-1:0] rdata_q;
	logic [`CSR_DATA_W-1:0] rdata_d;
	logic acc_rd;
	logic acc_wr;
	logic [7:0] rd_byte;

	csr_stat_t stat_q;
	csr_stat_t stat_d;
	logic [`CSR_IRQ_N-1:0] irq_en_q;
	logic [`CSR_IRQ_N-1:0] irq_en_d;
	logic [`CSR_EVT_W-1:0] evt_mask_q;
	logic [`CSR_EVT_W-1:0] evt_mask_d;
	logic [`CSR_EVT_W-1:0] evt_stat;
	logic [`CSR_EVT_W-1:0] evt_set;
	logic [`CSR_EVT_W-1:0] evt_clr;
	logic [7:0] status_d;
	logic irq_d;

	logic wr_lane0;
	logic wr_status;
	logic wr_irq_en;
	logic wr_evt_mask;
	logic rd_evt_stat;
	logic dev_rst;
	logic stack_hit;
	logic bor_hit;

	// ---------------- bus slave ----------------

	// single unbanked slot
	// unmapped offsets read zero and are still answered
	always_comb begin
		unique case (AVS_ADDRESS)
			`CSR_ADDR_STATUS: begin
				rd_byte = {2'b00, stat_q};
			end
			`CSR_ADDR_IRQ_EN: begin
				rd_byte = irq_en_q;
			end
			`CSR_ADDR_IRQ_SRC: begin
				rd_byte = IRQ_SRC;
			end
			`CSR_ADDR_EVT_STAT: begin
				rd_byte = {3'b000, evt_stat};
			end
			`CSR_ADDR_EVT_MASK: begin
				rd_byte = {3'b000, evt_mask_q};
			end
			`CSR_ADDR_STACK: begin
				rd_byte = {4'h0, STACK_PTR};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// the ack state keeps a request that is still held from being taken
	// twice; waitrequest drops for exactly one cycle per access
	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		unique case (bus_q)
			CSR_BUS_IDLE: begin
				if (AVS_READ || AVS_WRITE) begin
					bus_d = CSR_BUS_ACK;
					wait_d = 1'b0;
					acc_rd = AVS_READ;
					acc_wr = AVS_WRITE & ~AVS_READ;
					// read data is the byte as it stood before this edge
					if (AVS_READ) begin
						rdata_d = {24'h000000, rd_byte};
					end
				end
			end
			CSR_BUS_ACK: begin
				bus_d = CSR_BUS_IDLE;
			end
			default: begin
				bus_d = CSR_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bus_q <= CSR_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// both straight from flops; read data holds until the next read
	assign AVS_WAITREQUEST = wait_q;
	assign AVS_READDATA = rdata_q;

	// ---------------- decode ----------------

	always_comb begin
		// every register lives in byte lane 0
		wr_lane0 = acc_wr & AVS_BYTEENABLE[0];
		wr_status = wr_lane0 & (AVS_ADDRESS == `CSR_ADDR_STATUS);
		wr_irq_en = wr_lane0 & (AVS_ADDRESS == `CSR_ADDR_IRQ_EN);
		wr_evt_mask = wr_lane0 & (AVS_ADDRESS == `CSR_ADDR_EVT_MASK);
		rd_evt_stat = acc_rd & (AVS_ADDRESS == `CSR_ADDR_EVT_STAT);
		// any reset source restores stack room and the mask
		dev_rst = EVT.por | EVT.bor | EVT.ext_rst;
		stack_hit = (STACK_PTR == `CSR_SP_FULL) | EVT.stk_ovf;
		// brown-out with detection off leaves bit 0 and events alone
		bor_hit = EVT.bor & BOD_EN;
	end

	// ---------------- status byte ----------------

	// later assignments win: write, then events, then reset sources
	always_comb begin
		stat_d = stat_q;
		// only mask, por and bor are writable
		if (wr_status) begin
			stat_d.global_irq_mask = AVS_WRITEDATA[`CSR_BIT_GLOBAL_MASK];
			stat_d.por_flag = AVS_WRITEDATA[`CSR_BIT_POR];
			stat_d.brownout_reset_flag = AVS_WRITEDATA[`CSR_BIT_BOR];
		end
		// events act on the next edge
		if (EVT.wdt_clear || EVT.sleep) begin
			stat_d.watchdog_expiry_flag = 1'b1;
		end
		if (EVT.wdt_timeout) begin
			stat_d.watchdog_expiry_flag = 1'b0;
		end
		if (EVT.wdt_clear) begin
			stat_d.powerdown_flag = 1'b1;
		end
		if (EVT.sleep) begin
			stat_d.powerdown_flag = 1'b0;
		end
		// only a device reset restores room
		if (dev_rst) begin
			stat_d.stack_room_flag = 1'b1;
			stat_d.global_irq_mask = 1'b1;
		end else if (stack_hit) begin
			stat_d.stack_room_flag = 1'b0;
		end
		if (EVT.por) begin
			stat_d = csr_stat_t'(`CSR_STAT_RST);
		end
		// bit left alone when detection off
		if (bor_hit) begin
			stat_d.brownout_reset_flag = 1'b0;
		end
	end

	// reset is the power-on value
	// an async reset counts as power-on, so the por bit reads 0
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stat_q <= csr_stat_t'(`CSR_STAT_RST);
		end else begin
			stat_q <= stat_d;
		end
	end

	// ---------------- enables and masks ----------------

	always_comb begin
		irq_en_d = irq_en_q;
		evt_mask_d = evt_mask_q;
		if (wr_irq_en) begin
			irq_en_d = AVS_WRITEDATA[`CSR_IRQ_N-1:0];
		end
		if (wr_evt_mask) begin
			evt_mask_d = AVS_WRITEDATA[`CSR_EVT_W-1:0];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			irq_en_q <= `CSR_IRQ_EN_RST;
			evt_mask_q <= `CSR_EVT_RST;
		end else begin
			irq_en_q <= irq_en_d;
			evt_mask_q <= evt_mask_d;
		end
	end

	// ---------------- event status, read to clear ----------------

	always_comb begin
		evt_set = '0;
		evt_set[`CSR_EVT_WDT_TIMEOUT] = EVT.wdt_timeout;
		evt_set[`CSR_EVT_SLEEP] = EVT.sleep;
		evt_set[`CSR_EVT_POR] = EVT.por;
		evt_set[`CSR_EVT_BOR] = bor_hit;
		// overflow event only as the room flag falls, not while full
		evt_set[`CSR_EVT_STK_OVF] = stack_hit & stat_q.stack_room_flag
			& ~dev_rst;
		// a read clears all bits; a set in the same cycle still wins
		evt_clr = {`CSR_EVT_W{rd_evt_stat}};
	end

	csr_sticky #(
		.W(`CSR_EVT_W)
	) u_evt (
		.clk(CLK),
		.rst(RST),
		.set(evt_set),
		.clr(evt_clr),
		.q(evt_stat)
	);

	// ---------------- outputs ----------------

	csr_irqgate #(
		.N(`CSR_IRQ_N)
	) u_gate (
		.clk(CLK),
		.rst(RST),
		.src(IRQ_SRC),
		.en(irq_en_q),
		.gmask(stat_q.global_irq_mask),
		.irq(CORE_IRQ)
	);

	always_comb begin
		// level request, one cycle behind the sticky bits
		irq_d = |(evt_stat & evt_mask_q);
		// mirrors the stored byte, so it matches stat_q after each edge
		// bits 7,6 driven zero
		status_d = {2'b00, stat_d};
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
			STATUS_OUT <= {2'b00, `CSR_STAT_RST};
		end else begin
			IRQ <= irq_d;
			STATUS_OUT <= status_d;
		end
	end

endmodule : csr_top

// file: verilog/csr_cfg.svh
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// bus geometry
`define CSR_ADDR_W 8
`define CSR_DATA_W 32
`define CSR_BE_W 4

// register index of the cpu status/control byte and its byte address
`define CSR_IDX_STATUS 8'h06
`define CSR_ADDR_STATUS (`CSR_IDX_STATUS << 2)

// added registers, byte addresses
`define CSR_ADDR_IRQ_EN 8'h00
`define CSR_ADDR_IRQ_SRC 8'h04
`define CSR_ADDR_EVT_STAT 8'h08
`define CSR_ADDR_EVT_MASK 8'h0C
`define CSR_ADDR_STACK 8'h10

// status byte field positions
`define CSR_BIT_STACK_ROOM 5
`define CSR_BIT_GLOBAL_MASK 4
`define CSR_BIT_WDT_EXPIRY 3
`define CSR_BIT_POWERDOWN 2
`define CSR_BIT_POR 1
`define CSR_BIT_BOR 0
`define CSR_STAT_W 6
`define CSR_STAT_RST 6'h3D

// event status field positions
`define CSR_EVT_WDT_TIMEOUT 0
`define CSR_EVT_SLEEP 1
`define CSR_EVT_POR 2
`define CSR_EVT_BOR 3
`define CSR_EVT_STK_OVF 4
`define CSR_EVT_W 5
`define CSR_EVT_RST 5'h00

// interrupt sources and stack pointer
`define CSR_IRQ_N 8
`define CSR_IRQ_EN_RST 8'h00
`define CSR_SP_W 4
`define CSR_SP_FULL 4'hF

`endif

// file: verilog/csr_pkg.sv
package csr_pkg;

	typedef enum logic [1:0] {
		CSR_BUS_IDLE = 2'b01,
		CSR_BUS_ACK = 2'b10
	} csr_bus_st_t;

	// one-cycle event pulses from the core and reset logic
	typedef struct packed {
		logic wdt_timeout;
		logic wdt_clear;
		logic sleep;
		logic por;
		logic bor;
		logic ext_rst;
		logic stk_ovf;
	} csr_evt_t;

	// status byte bits 5..0, msb first
	typedef struct packed {
		logic stack_room_flag;
		logic global_irq_mask;
		logic watchdog_expiry_flag;
		logic powerdown_flag;
		logic por_flag;
		logic brownout_reset_flag;
	} csr_stat_t;

endpackage : csr_pkg

// file: verilog/csr_sticky.sv
`timescale 1ns/100ps
module csr_sticky #(
	parameter int W = 5
) (
	input wire logic clk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic [W-1:0] set, // event pulses
	input wire logic [W-1:0] clr, // clear request
	output logic [W-1:0] q // sticky bits
);

	logic [W-1:0] q_d;

	// set beats a clear in the same cycle
	always_comb begin
		q_d = (q & ~clr) | set;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= q_d;
		end
	end

endmodule : csr_sticky

// file: verilog/csr_irqgate.sv
`timescale 1ns/100ps
module csr_irqgate #(
	parameter int N = 8
) (
	input wire logic clk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic [N-1:0] src, // pending source flags
	input wire logic [N-1:0] en, // per-source enables
	input wire logic gmask, // 1 blocks everything
	output logic irq // registered request to core
);

	logic irq_d;

	always_comb begin
		irq_d = ~gmask & (|(src & en));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_d;
		end
	end

endmodule : csr_irqgate

// file: bench/csr_props.sv
`timescale 1ns/100ps
module csr_props
	import csr_pkg::*;
(
	input wire logic CLK, // clock
	input wire logic RST, // reset
	input wire csr_evt_t EVT, // events
	input wire logic [3:0] STACK_PTR, // stack ptr
	input wire logic BOD_EN, // detection on
	input wire logic [7:0] IRQ_SRC, // sources
	input wire logic CORE_IRQ, // gated irq
	input wire logic [7:0] STATUS_OUT // status byte
);
	logic dev_rst;
	assign dev_rst = EVT.por | EVT.bor | EVT.ext_rst;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	property p_gmask;
		STATUS_OUT[4] |=> !CORE_IRQ;
	endproperty
	a_gmask: assert property (p_gmask) else $error("irq past mask");
	property p_nosrc;
		IRQ_SRC == 8'h00 |=> !CORE_IRQ;
	endproperty
	a_nosrc: assert property (p_nosrc) else $error("irq no source");
	property p_unimp;
		STATUS_OUT[7:6] == 2'h0;
	endproperty
	a_unimp: assert property (p_unimp) else $error("bits 7:6 set");
	property p_full;
		STACK_PTR == 4'hF && !dev_rst |=> !STATUS_OUT[5];
	endproperty
	a_full: assert property (p_full) else $error("room flag kept");
	property p_stick;
		!STATUS_OUT[5] && !dev_rst |=> !STATUS_OUT[5];
	endproperty
	a_stick: assert property (p_stick) else $error("room flag rose");
	property p_tmo;
		EVT.wdt_timeout && !EVT.por |=> !STATUS_OUT[3];
	endproperty
	a_tmo: assert property (p_tmo) else $error("expiry kept");
	property p_sleep;
		EVT.sleep && !EVT.wdt_timeout && !EVT.por |=> STATUS_OUT[3:2] == 2'h2;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags");
	property p_por;
		EVT == 7'h08 |=> STATUS_OUT == 8'h3D;
	endproperty
	a_por: assert property (p_por) else $error("power-on value");
	sequence s_clear_only;
		EVT.wdt_clear && !EVT.sleep && !EVT.wdt_timeout && !EVT.por;
	endsequence
	sequence s_flags_up;
		STATUS_OUT[3:2] == 2'h3;
	endsequence
	property p_clear;
		s_clear_only |=> s_flags_up;
	endproperty
	a_clear: assert property (p_clear) else $error("clear flags");
	property p_bor;
		EVT.bor && BOD_EN && !EVT.por |=> !STATUS_OUT[0];
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out kept");
endmodule : csr_props
bind csr_top csr_props csr_props_i (.CLK(CLK), .RST(RST), .EVT(EVT),
	.STACK_PTR(STACK_PTR), .BOD_EN(BOD_EN), .IRQ_SRC(IRQ_SRC),
	.CORE_IRQ(CORE_IRQ),
	.STATUS_OUT(STATUS_OUT));

// file: bench/csr_core_model.sv
`timescale 1ns/100ps
module csr_core_model
	import csr_pkg::*;
(
	input wire logic CLK, // core clock
	output csr_evt_t EVT, // event pulses
	output logic [3:0] STACK_PTR, // stack pointer
	output logic [7:0] IRQ_SRC // pending sources
);
	initial begin
		EVT = '0;
		STACK_PTR = 4'h0;
		IRQ_SRC = 8'h00;
	end
	task automatic pulse(input csr_evt_t e);
		@(posedge CLK);
		EVT <= e;
		@(posedge CLK);
		EVT <= '0;
	endtask : pulse
	task automatic lines(input logic [3:0] sp, input logic [7:0] src);
		STACK_PTR <= sp;
		IRQ_SRC <= src;
	endtask : lines
endmodule : csr_core_model

// file: bench/csr_top_bench.sv
`timescale 1ns/100ps
module cpu_status_reset_flags_bench
	import csr_pkg::*;
;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h00000000;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic BOD_EN = 1'b1;
	csr_evt_t EVT;
	logic [3:0] STACK_PTR;
	logic [7:0] IRQ_SRC;
	logic CORE_IRQ;
	logic IRQ;
	logic [7:0] STATUS_OUT;
	logic [7:0] r;
	logic [6:0] ev [9] = '{7'h10, 7'h20, 7'h40, 7'h60, 7'h20, 7'h04, 7'h01,
		7'h20, 7'h08};
	logic [7:0] ex [9] = '{8'h2B, 8'h2F, 8'h27, 8'h27, 8'h2F, 8'h3E, 8'h1E,
		8'h1E, 8'h3D};
	int n_fail = 0;
	int n_tests = 0;
	csr_top csr_top_i (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.EVT(EVT), .STACK_PTR(STACK_PTR), .BOD_EN(BOD_EN),
		.IRQ_SRC(IRQ_SRC), .CORE_IRQ(CORE_IRQ), .STATUS_OUT(STATUS_OUT),
		.IRQ(IRQ));
	csr_core_model csr_core_model_i (.CLK(CLK), .EVT(EVT),
		.STACK_PTR(STACK_PTR), .IRQ_SRC(IRQ_SRC));
	initial begin
		forever #2 CLK = ~CLK;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// hold the request until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do @(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0);
		r = AVS_READDATA[7:0];
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e,
		input string n);
		acc(1'b0, a, 8'h00);
		chk(n, e, r);
	endtask : rdc
	initial begin
		repeat (2000) @(posedge CLK);
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		rdc(8'h18, 8'h3D, "status");
		wr(8'h18, 8'hFF);
		rdc(8'h18, 8'h3F, "status");
		wr(8'h18, 8'h00);
		rdc(8'h18, 8'h2C, "status");
		rdc(8'h40, 8'h00, "unmapped");
		$display("test bus done");
		wr(8'h00, 8'h01);
		rdc(8'h00, 8'h01, "irq_en");
		csr_core_model_i.lines(4'h0, 8'h01);
		repeat (2) @(posedge CLK);
		chk("core_irq", 8'h01, {7'h00, CORE_IRQ});
		rdc(8'h04, 8'h01, "irq_src");
		csr_core_model_i.lines(4'h0, 8'h02);
		repeat (2) @(posedge CLK);
		chk("core_irq", 8'h00, {7'h00, CORE_IRQ});
		csr_core_model_i.lines(4'h0, 8'h01);
		wr(8'h18, 8'h10);
		repeat (2) @(posedge CLK);
		chk("core_irq", 8'h00, {7'h00, CORE_IRQ});
		wr(8'h18, 8'h03);
		wr(8'h0C, 8'h02);
		$display("test irq done");
		for (int i = 0; i < 9; i++) begin
			csr_core_model_i.pulse(csr_evt_t'(ev[i]));
			#1 chk("status_out", ex[i], STATUS_OUT);
		end
		chk("irq", 8'h01, {7'h00, IRQ});
		wr(8'h0C, 8'h00);
		@(posedge CLK);
		chk("irq", 8'h00, {7'h00, IRQ});
		wr(8'h0C, 8'h02);
		rdc(8'h0C, 8'h02, "evt_mask");
		chk("irq", 8'h01, {7'h00, IRQ});
		rdc(8'h08, 8'h1F, "evt_stat");
		@(posedge CLK);
		chk("irq", 8'h00, {7'h00, IRQ});
		$display("test events done");
		csr_core_model_i.lines(4'hF, 8'h00);
		repeat (2) @(posedge CLK);
		rdc(8'h10, 8'h0F, "stack_ptr");
		csr_core_model_i.lines(4'h0, 8'h00);
		repeat (2) @(posedge CLK);
		chk("status_out", 8'h1D, STATUS_OUT);
		csr_core_model_i.pulse(csr_evt_t'(7'h02));
		#1 chk("status_out", 8'h3D, STATUS_OUT);
		$display("test stack done");
		@(posedge CLK);
		BOD_EN <= 1'b0;
		csr_core_model_i.pulse(csr_evt_t'(7'h04));
		#1 chk("status_out", 8'h3D, STATUS_OUT);
		rdc(8'h08, 8'h10, "evt_stat");
		$display("test brown-out off done");
		end_of_test();
	end
endmodule : cpu_status_reset_flags_bench
